// ### verilog/power_bank_pkg.sv
// Constants, carriers and state layout for the power module command and status bank.
// Assumes a transaction layer that presents one decoded command per cycle on a single clock.
package power_bank_pkg;

	// Command codes
	localparam logic [7:0] CODE_OPERATION = 8'h01;
	localparam logic [7:0] CODE_ON_OFF = 8'h02;
	localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CODE_STORE_ALL = 8'h11;
	localparam logic [7:0] CODE_RESTORE_ALL = 8'h12;
	localparam logic [7:0] CODE_VOUT_FORMAT = 8'h20;
	localparam logic [7:0] CODE_VOUT_SETPOINT = 8'h21;
	localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
	localparam logic [7:0] CODE_OUTPUT_VOLTAGE_STATUS = 8'h7a;
	localparam logic [7:0] CODE_OUTPUT_CURRENT_STATUS = 8'h7b;
	localparam logic [7:0] CODE_STATUS_INPUT = 8'h7c;
	localparam logic [7:0] CODE_STATUS_TEMP = 8'h7d;
	localparam logic [7:0] CODE_COMMUNICATION_STATUS = 8'h7e;

	// Values after reset and access masks
	localparam logic [7:0] OPERATION_RESET = 8'h88;
	localparam logic [7:0] OPERATION_WR_MASK = 8'hb0;
	localparam logic [7:0] ON_OFF_FIXED = 8'h19;
	localparam logic [7:0] ON_OFF_WR_MASK = 8'h04;
	localparam logic [7:0] VOUT_FORMAT_VALUE = 8'h14;
	localparam logic [15:0] VOUT_SETPOINT_RESET = 16'hc000;

	// Field positions
	localparam int OP_ON_BIT = 7;
	localparam int OP_MARGIN_LSB = 2;
	localparam logic [3:0] MARGIN_LOW_CODE = 4'h6;
	localparam logic [3:0] MARGIN_HIGH_CODE = 4'ha;
	localparam int ON_OFF_CPR_BIT = 2;
	localparam int ON_OFF_POL_BIT = 1;
	localparam int WORD_VOUT_BIT = 15;
	localparam int WORD_IOUT_BIT = 14;
	localparam int WORD_INPUT_BIT = 13;
	localparam int WORD_PGOOD_BIT = 11;
	localparam int WORD_OFF_BIT = 6;
	localparam int WORD_VOUT_OV_BIT = 5;
	localparam int WORD_IOUT_OC_BIT = 4;
	localparam int WORD_VIN_UV_BIT = 3;
	localparam int WORD_TEMP_BIT = 2;
	localparam int WORD_CML_BIT = 1;
	localparam int INPUT_UV_BIT = 4;
	localparam int INPUT_OFF_BIT = 3;
	localparam int IOUT_WARN_BIT = 5;
	localparam int TEMP_WARN_BIT = 6;
	localparam int FLAG_TOP_BIT = 7;
	localparam int CML_CMD_BIT = 7;
	localparam int CML_DATA_BIT = 6;
	localparam int CML_PEC_BIT = 5;

	// Supported flag positions of each detail byte
	localparam logic [7:0] VOUT_MASK = 8'h80;
	localparam logic [7:0] IOUT_MASK = 8'ha0;
	localparam logic [7:0] INPUT_MASK = 8'h98;
	localparam logic [7:0] TEMP_MASK = 8'hc0;
	localparam logic [7:0] CML_MASK = 8'he0;

	// Setpoint window in millivolts, converted to mantissa counts at 2^-12 volt
	localparam int VOUT_SCALE = 4096;
	localparam int VOUT_MIN_MV = 5000;
	localparam int VOUT_MAX_MV = 13200;
	localparam logic [15:0] VOUT_MIN_CODE = 16'((VOUT_MIN_MV * VOUT_SCALE + 999) / 1000);
	localparam logic [15:0] VOUT_MAX_CODE = 16'((VOUT_MAX_MV * VOUT_SCALE) / 1000);

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} cmd_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} cmd_rsp_t;

	// Levels from the analog protection circuits and the option strap
	typedef struct packed {
		logic vout_ov;
		logic iout_oc;
		logic iout_oc_warn;
		logic vin_ov;
		logic vin_uv;
		logic vin_low_off;
		logic ot_fault;
		logic ot_warn;
		logic unit_off;
		logic power_not_good;
		logic pol_positive;
	} fault_in_t;

	typedef struct packed {
		logic output_on;
		logic margin_low;
		logic margin_high;
		logic [15:0] vout_setpoint;
		logic [7:0] on_off_config;
	} control_out_t;

	typedef struct packed {
		logic [7:0] op;
		logic cpr;
		logic [15:0] vout;
		logic [7:0] nv_op;
		logic nv_cpr;
		logic [15:0] nv_vout;
		logic [7:0] st_vout;
		logic [7:0] st_iout;
		logic [7:0] st_input;
		logic [7:0] st_temp;
		logic [7:0] st_cml;
		cmd_rsp_t rsp;
	} bank_state_t;

	localparam bank_state_t BANK_RESET = '{
		op: OPERATION_RESET,
		cpr: 1'b1,
		vout: VOUT_SETPOINT_RESET,
		nv_op: OPERATION_RESET,
		nv_cpr: 1'b1,
		nv_vout: VOUT_SETPOINT_RESET,
		st_vout: 8'h00,
		st_iout: 8'h00,
		st_input: 8'h00,
		st_temp: 8'h00,
		st_cml: 8'h00,
		rsp: '{valid: 1'b0, data: 16'h0000}
	};

endpackage

// ### verilog/level_sync.sv
// Two-stage synchroniser for a bank of asynchronous levels.
// Assumes the levels change slowly against the clock; no event is carried, only a level.
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 11
) (
	input wire clock,
	input wire nrst,
	input wire [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] synced
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// Refuse an empty bank
	if (WIDTH < 1) begin : g_bad_width
		$error("level_sync needs WIDTH of at least one");
	end

	// First stage feeds only the second stage
	always_comb begin
		next_s.meta = async_in;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign synced = s.stable;

endmodule

// ### verilog/power_status_command_bank.sv
// Command and status bank of a power module behind its management bus slave.
// Assumes the transaction layer hands over one decoded command per cycle and reports
// packet check failures as a one-cycle pulse; fault levels arrive asynchronously.
// Operation
// - Word high byte: vout, iout, input, power-not-good
// - Word low byte: off, OV, OC, UV, temp, comm
// - Unsupported status bits read zero; all default zero
// - Output voltage status: only bit 7 overvoltage
// - Current status: fault bit 7, warning bit 5
// - Input status: OV bit 7, UV 4, off 3
// - Temperature status: fault bit 7, warning 6
// - Comm status: bad command, bad data, checksum
// - Operation: immediate on/off, margins acting on faults
// - Operation writable bits 7,5,4; others fixed
// - Margin field 0110 low, 1010 high
// - On/off config bit 1 shows strap polarity
// - On/off config: only bit 2 writable
// - Clear faults fully implemented
// - Store-all copies parameters to non-volatile image
// - Restore-all reloads parameters from non-volatile image
// - Output format reads fixed 0x14, exponent -12
// - Setpoint is 16-bit mantissa, default 0xC000
// - Setpoint unsupported while hardware trim selected
`timescale 1ns/1ps
module power_status_command_bank
	import power_bank_pkg::*;
(
	input wire clock,
	input wire nrst,
	input cmd_req_t cmd,
	input wire pec_error,
	input wire trim_select_active,
	input fault_in_t fault_pins,
	output cmd_rsp_t rsp,
	output control_out_t ctrl
);

	bank_state_t s;
	bank_state_t next_s;
	fault_in_t faults;

	// Fault levels and the strap come from outside the clock domain
	level_sync #(
		.WIDTH($bits(fault_in_t))
	) u_fault_sync (
		.clock(clock),
		.nrst(nrst),
		.async_in(fault_pins),
		.synced(faults)
	);

	// Refuse constant sets that the decode below cannot serve; a wrong carrier width
	// would shift every level onto the wrong flag
	if ($bits(fault_in_t) != 11) begin : g_bad_fault_bank
		$error("fault carrier must hold eleven levels");
	end
	if (VOUT_MIN_CODE >= VOUT_MAX_CODE) begin : g_bad_window
		$error("setpoint window is empty");
	end
	// A reset image holding a margin code would move the output before any host command
	if (OPERATION_RESET[OP_MARGIN_LSB +: 4] == MARGIN_LOW_CODE
		|| OPERATION_RESET[OP_MARGIN_LSB +: 4] == MARGIN_HIGH_CODE) begin : g_bad_op_reset
		$error("operation reset image must leave margins off");
	end

	// True when a write tries to change a bit that is fixed
	function automatic logic ro_violation(input logic [7:0] wr, input logic [7:0] cur,
		input logic [7:0] wr_mask);
		ro_violation = |((wr ^ cur) & ~wr_mask);
	endfunction

	// Keep fixed bits, take writable ones
	function automatic logic [7:0] merge_bits(input logic [7:0] wr, input logic [7:0] cur,
		input logic [7:0] wr_mask);
		merge_bits = (wr & wr_mask) | (cur & ~wr_mask);
	endfunction

	// Sticky flag byte: a new event wins over a clear in the same cycle
	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
		input logic clr, input logic [7:0] mask);
		logic [7:0] held;
		held = clr ? 8'h00 : cur;
		sticky = (held | set) & mask;
	endfunction

	// Full on/off configuration byte from fixed bits, the writable bit and the strap
	function automatic logic [7:0] on_off_value(input logic cpr, input logic pol);
		logic [7:0] v;
		v = ON_OFF_FIXED;
		v[ON_OFF_CPR_BIT] = cpr;
		v[ON_OFF_POL_BIT] = pol;
		on_off_value = v;
	endfunction

	// Read-side views of the state
	logic [15:0] status_word;
	logic [3:0] margin_field;
	logic [7:0] cur_on_off;

	// Summary word built from the latched detail bytes and live module state
	always_comb begin
		status_word = 16'h0000;
		status_word[WORD_VOUT_BIT] = |(s.st_vout & VOUT_MASK);
		status_word[WORD_IOUT_BIT] = |(s.st_iout & IOUT_MASK);
		status_word[WORD_INPUT_BIT] = |(s.st_input & INPUT_MASK);
		status_word[WORD_PGOOD_BIT] = faults.power_not_good;
		status_word[WORD_OFF_BIT] = ~s.op[OP_ON_BIT] | faults.unit_off;
		status_word[WORD_VOUT_OV_BIT] = s.st_vout[FLAG_TOP_BIT];
		status_word[WORD_IOUT_OC_BIT] = s.st_iout[FLAG_TOP_BIT];
		status_word[WORD_VIN_UV_BIT] = s.st_input[INPUT_UV_BIT];
		status_word[WORD_TEMP_BIT] = |(s.st_temp & TEMP_MASK);
		status_word[WORD_CML_BIT] = |(s.st_cml & CML_MASK);
	end

	assign cur_on_off = on_off_value(s.cpr, faults.pol_positive);
	assign margin_field = s.op[OP_MARGIN_LSB +: 4];

	// Flag events and decode strobes of this cycle
	logic [7:0] set_vout;
	logic [7:0] set_iout;
	logic [7:0] set_input;
	logic [7:0] set_temp;
	logic [7:0] set_cml;
	logic cml_bad_cmd;
	logic cml_bad_data;
	logic clear_all;
	logic is_write;

	// Command decode, register updates, answers and flag bookkeeping
	always_comb begin
		next_s = s;
		next_s.rsp.valid = 1'b0;
		next_s.rsp.data = 16'h0000;
		cml_bad_cmd = 1'b0;
		cml_bad_data = 1'b0;
		clear_all = 1'b0;
		is_write = cmd.write;

		// Fault levels that have been seen set their flags
		set_vout = 8'h00;
		set_vout[FLAG_TOP_BIT] = faults.vout_ov;
		set_iout = 8'h00;
		set_iout[FLAG_TOP_BIT] = faults.iout_oc;
		set_iout[IOUT_WARN_BIT] = faults.iout_oc_warn;
		set_input = 8'h00;
		set_input[FLAG_TOP_BIT] = faults.vin_ov;
		set_input[INPUT_UV_BIT] = faults.vin_uv;
		set_input[INPUT_OFF_BIT] = faults.vin_low_off;
		set_temp = 8'h00;
		set_temp[FLAG_TOP_BIT] = faults.ot_fault;
		set_temp[TEMP_WARN_BIT] = faults.ot_warn;

		if (cmd.valid) begin
			next_s.rsp.valid = 1'b1;
			case (cmd.code)
				CODE_OPERATION: begin
					if (is_write) begin
						// Sequenced soft-off and ignore-fault margins stay locked out
						cml_bad_data = ro_violation(cmd.data[7:0], s.op, OPERATION_WR_MASK);
						next_s.op = merge_bits(cmd.data[7:0], s.op, OPERATION_WR_MASK);
					end else begin
						next_s.rsp.data = {8'h00, s.op};
					end
				end
				CODE_ON_OFF: begin
					if (is_write) begin
						cml_bad_data = ro_violation(cmd.data[7:0], cur_on_off, ON_OFF_WR_MASK);
						next_s.cpr = cmd.data[ON_OFF_CPR_BIT];
					end else begin
						next_s.rsp.data = {8'h00, cur_on_off};
					end
				end
				// Send-only commands: reading one of them is an unsupported command
				CODE_CLEAR_FAULTS: begin
					if (is_write) begin
						clear_all = 1'b1;
					end else begin
						cml_bad_cmd = 1'b1;
					end
				end
				CODE_STORE_ALL: begin
					if (is_write) begin
						next_s.nv_op = s.op;
						next_s.nv_cpr = s.cpr;
						next_s.nv_vout = s.vout;
					end else begin
						cml_bad_cmd = 1'b1;
					end
				end
				CODE_RESTORE_ALL: begin
					if (is_write) begin
						next_s.op = s.nv_op;
						next_s.cpr = s.nv_cpr;
						next_s.vout = s.nv_vout;
					end else begin
						cml_bad_cmd = 1'b1;
					end
				end
				CODE_VOUT_FORMAT: begin
					if (is_write) begin
						cml_bad_data = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, VOUT_FORMAT_VALUE};
					end
				end
				CODE_VOUT_SETPOINT: begin
					// The analog trim pin owns the setpoint when selected
					if (trim_select_active) begin
						cml_bad_cmd = 1'b1;
					end else if (!is_write) begin
						next_s.rsp.data = s.vout;
					end else if (cmd.data < VOUT_MIN_CODE || cmd.data > VOUT_MAX_CODE) begin
						// Out-of-window value: the running setpoint keeps driving the stage
						cml_bad_data = 1'b1;
					end else begin
						next_s.vout = cmd.data;
					end
				end
				// Status registers are read-only; a write to one is an unsupported command
				CODE_STATUS_WORD: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = status_word;
					end
				end
				CODE_OUTPUT_VOLTAGE_STATUS: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, s.st_vout & VOUT_MASK};
					end
				end
				CODE_OUTPUT_CURRENT_STATUS: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, s.st_iout & IOUT_MASK};
					end
				end
				CODE_STATUS_INPUT: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, s.st_input & INPUT_MASK};
					end
				end
				CODE_STATUS_TEMP: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, s.st_temp & TEMP_MASK};
					end
				end
				CODE_COMMUNICATION_STATUS: begin
					if (is_write) begin
						cml_bad_cmd = 1'b1;
					end else begin
						next_s.rsp.data = {8'h00, s.st_cml & CML_MASK};
					end
				end
				// Codes outside this bank, later limit and measurement commands included
				default: begin
					cml_bad_cmd = 1'b1;
				end
			endcase
		end

		// Communication events of this cycle
		set_cml = 8'h00;
		set_cml[CML_CMD_BIT] = cml_bad_cmd;
		set_cml[CML_DATA_BIT] = cml_bad_data;
		set_cml[CML_PEC_BIT] = pec_error;

		// Flags hold until a clear; a fault still present sets again at once
		next_s.st_vout = sticky(s.st_vout, set_vout, clear_all, VOUT_MASK);
		next_s.st_iout = sticky(s.st_iout, set_iout, clear_all, IOUT_MASK);
		next_s.st_input = sticky(s.st_input, set_input, clear_all, INPUT_MASK);
		next_s.st_temp = sticky(s.st_temp, set_temp, clear_all, TEMP_MASK);
		next_s.st_cml = sticky(s.st_cml, set_cml, clear_all, CML_MASK);
	end

	// Single state register; reset loads the factory image
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s <= BANK_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Answer leaves straight from the state register
	assign rsp = s.rsp;

	// Drive to the power stage; a margin code other than the two accepted ones means nominal
	always_comb begin
		ctrl.output_on = s.op[OP_ON_BIT];
		ctrl.margin_low = (margin_field == MARGIN_LOW_CODE);
		ctrl.margin_high = (margin_field == MARGIN_HIGH_CODE);
		ctrl.vout_setpoint = s.vout;
		ctrl.on_off_config = cur_on_off;
	end

endmodule

// ### tb/bank_monitor.sv
// Checker for the command and status bank, bound to its top module.
// Assumes one decoded command per cycle and an answer one cycle later.
`timescale 1ns/1ps
module bank_monitor
	import power_bank_pkg::*;
(
	input wire clock,
	input wire nrst,
	input cmd_req_t cmd,
	input wire pec_error,
	input wire trim_select_active,
	input fault_in_t fault_pins,
	input cmd_rsp_t rsp,
	input control_out_t ctrl
);
	default clocking mon_clk @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// Decoded command kinds, kept short for the properties
	logic rd_cmd;
	logic wr_cmd;
	logic sp_wr;
	assign rd_cmd = cmd.valid && !cmd.write;
	assign wr_cmd = cmd.valid && cmd.write;
	assign sp_wr = wr_cmd && cmd.code == CODE_VOUT_SETPOINT;

	a_answer_one_cycle: assert property (cmd.valid |=> rsp.valid)
		else $error("command got no answer");
	a_no_stray_answer: assert property (rsp.valid |-> $past(cmd.valid))
		else $error("answer without command");
	a_format_fixed: assert property (rd_cmd && cmd.code == CODE_VOUT_FORMAT |=> rsp.data == 16'h0014)
		else $error("format read wrong");
	a_write_gives_zero: assert property (wr_cmd |=> rsp.data == 16'h0000)
		else $error("write answer not zero");
	a_margin_decode: assert property (wr_cmd && cmd.code == CODE_OPERATION |=>
		ctrl.output_on == $past(cmd.data[7]) && ctrl.margin_low == ($past(cmd.data[5:4]) == 2'b01)
		&& ctrl.margin_high == ($past(cmd.data[5:4]) == 2'b10))
		else $error("operation outputs wrong");
	a_on_off_fixed: assert property ((ctrl.on_off_config & 8'hf9) == 8'h19)
		else $error("fixed config bits moved");
	a_word_unsupported: assert property (rd_cmd && cmd.code == CODE_STATUS_WORD |=>
		(rsp.data & 16'h1781) == 16'h0000)
		else $error("unsupported word bit set");
	a_iout_layout: assert property (rd_cmd && cmd.code == CODE_OUTPUT_CURRENT_STATUS |=>
		(rsp.data & 16'hff5f) == 16'h0000)
		else $error("unsupported current bit set");
	a_setpoint_hold: assert property (!sp_wr && !(cmd.valid && cmd.code == CODE_RESTORE_ALL) |=>
		$stable(ctrl.vout_setpoint))
		else $error("setpoint moved without write");
	a_range_refused: assert property (sp_wr && (cmd.data < VOUT_MIN_CODE || cmd.data > VOUT_MAX_CODE
		|| trim_select_active) |=> $stable(ctrl.vout_setpoint))
		else $error("refused setpoint taken");
	// Main scenarios reached
	c_trim_write: cover property (sp_wr && trim_select_active);
	c_margin_low: cover property (wr_cmd && cmd.code == CODE_OPERATION && cmd.data[5:2] == MARGIN_LOW_CODE);
	c_pec_pulse: cover property (pec_error);
endmodule

bind power_status_command_bank bank_monitor bank_monitor_inst (.clock(clock), .nrst(nrst), .cmd(cmd),
	.pec_error(pec_error), .trim_select_active(trim_select_active), .fault_pins(fault_pins),
	.rsp(rsp), .ctrl(ctrl));

// ### tb/host_model.sv
// Host side model: issues one command at a time and collects its answer.
// Assumes the bank answers exactly one cycle after taking a command.
`timescale 1ns/1ps
module host_model
	import power_bank_pkg::*;
(
	input wire clock,
	input cmd_rsp_t rsp,
	output cmd_req_t cmd
);
	// Bus idle until the first request
	initial begin
		cmd = '0;
	end
	// Request set after an edge, held to the taking edge; data inverted once released
	task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
		output logic [15:0] rdata, output logic ok);
		@(posedge clock);
		cmd <= '{valid: 1'b1, write: w, code: code, data: data};
		@(posedge clock);
		cmd.valid <= 1'b0;
		cmd.data <= ~data;
		@(posedge clock);
		ok = rsp.valid;
		rdata = rsp.data;
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the command and status bank with a host model.
// Assumes the bank answers each command one cycle after it is taken.
`timescale 1ns/1ps
module tb;
	import power_bank_pkg::*;
	logic clock;
	logic nrst;
	logic pec_error;
	logic trim_select_active;
	fault_in_t fault_pins;
	cmd_req_t cmd;
	cmd_rsp_t rsp;
	control_out_t ctrl;
	int n_fail;
	int comparisons;
	int cycles;
	logic [15:0] d;
	logic ok;

	power_status_command_bank power_status_command_bank_inst (.clock(clock), .nrst(nrst), .cmd(cmd),
		.pec_error(pec_error), .trim_select_active(trim_select_active), .fault_pins(fault_pins),
		.rsp(rsp), .ctrl(ctrl));
	host_model host_model_inst (.clock(clock), .rsp(rsp), .cmd(cmd));

	// 10 ns clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Hang guard, well above the roughly 145 cycles the tests need
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail = n_fail + 1;
			print_verdict();
		end
	end

	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Answer flag travels with the data so a missing answer is caught too
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		host_model_inst.xfer(1'b1, code, data, d, ok);
		chk({ok, d}, {1'b1, 16'h0000});
	endtask
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		host_model_inst.xfer(1'b0, code, 16'h0000, d, ok);
		chk({ok, d}, {1'b1, exp});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic t_defaults();
		rd(CODE_OPERATION, 16'h0088);
		rd(CODE_ON_OFF, 16'h001d);
		rd(CODE_VOUT_FORMAT, 16'h0014);
		rd(CODE_VOUT_SETPOINT, 16'hc000);
		rd(CODE_STATUS_WORD, 16'h0000);
		chk({ctrl.output_on, ctrl.vout_setpoint}, 17'h1_c000);
		$display("defaults done");
	endtask
	task automatic t_operation();
		wr(CODE_OPERATION, 16'h0098);
		chk({15'h0000, ctrl.margin_low, ctrl.margin_high}, 17'h0_0002);
		wr(CODE_OPERATION, 16'h00a8);
		chk({15'h0000, ctrl.margin_low, ctrl.margin_high}, 17'h0_0001);
		wr(CODE_OPERATION, 16'h0028);
		chk({16'h0000, ctrl.output_on}, 17'h0_0000);
		rd(CODE_OPERATION, 16'h0028);
		rd(CODE_STATUS_WORD, 16'h0040);
		wr(CODE_OPERATION, 16'h0080);
		rd(CODE_OPERATION, 16'h0088);
		rd(CODE_COMMUNICATION_STATUS, 16'h0040);
		rd(CODE_STATUS_WORD, 16'h0002);
		fault_pins.pol_positive <= 1'b1;
		idle(4);
		rd(CODE_ON_OFF, 16'h001f);
		wr(CODE_ON_OFF, 16'h001b);
		chk({9'h000, ctrl.on_off_config}, 17'h0_001b);
		rd(CODE_ON_OFF, 16'h001b);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		rd(CODE_COMMUNICATION_STATUS, 16'h0000);
		$display("operation done");
	endtask
	task automatic t_setpoint();
		wr(CODE_VOUT_SETPOINT, 16'h5000);
		wr(CODE_VOUT_SETPOINT, 16'hd334);
		rd(CODE_VOUT_SETPOINT, 16'h5000);
		rd(CODE_COMMUNICATION_STATUS, 16'h0040);
		trim_select_active <= 1'b1;
		wr(CODE_VOUT_SETPOINT, 16'h6000);
		trim_select_active <= 1'b0;
		rd(CODE_VOUT_SETPOINT, 16'h5000);
		rd(CODE_COMMUNICATION_STATUS, 16'h00c0);
		wr(CODE_STORE_ALL, 16'h0000);
		wr(CODE_VOUT_SETPOINT, 16'hd333);
		wr(CODE_RESTORE_ALL, 16'h0000);
		rd(CODE_VOUT_SETPOINT, 16'h5000);
		chk({1'b0, ctrl.vout_setpoint}, 17'h0_5000);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		rd(8'h55, 16'h0000);
		rd(CODE_COMMUNICATION_STATUS, 16'h0080);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		$display("setpoint done");
	endtask
	task automatic t_faults();
		fault_pins <= 11'h7fb;
		pec_error <= 1'b1;
		idle(1);
		pec_error <= 1'b0;
		idle(3);
		rd(CODE_OUTPUT_VOLTAGE_STATUS, 16'h0080);
		rd(CODE_OUTPUT_CURRENT_STATUS, 16'h00a0);
		rd(CODE_STATUS_INPUT, 16'h0098);
		rd(CODE_STATUS_TEMP, 16'h00c0);
		rd(CODE_COMMUNICATION_STATUS, 16'h0020);
		rd(CODE_STATUS_WORD, 16'he83e);
		fault_pins <= 11'h001;
		idle(4);
		rd(CODE_STATUS_WORD, 16'he03e);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		rd(CODE_STATUS_WORD, 16'h0000);
		$display("faults done");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Reset for three cycles, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		pec_error = 1'b0;
		trim_select_active = 1'b0;
		fault_pins = '0;
		idle(3);
		nrst <= 1'b1;
		t_defaults();
		t_operation();
		t_setpoint();
		t_faults();
		print_verdict();
	end
endmodule
